// file: rtl/ppm_defines.vh
`ifndef PPM_DEFINES_VH
`define PPM_DEFINES_VH

`define PPM_OFS_PMCS 8'hC4
`define PPM_OFS_MSI_CAPABILITY_CONTROL 8'hD0
`define PPM_OFS_MSILO 8'hD4
`define PPM_OFS_MSIUP 8'hD8
`define PPM_OFS_MSIDATA 8'hDC
`define PPM_OFS_PORTCFG 8'hE0

`define PPM_PS_LO 1
`define PPM_PS_HI 0
`define PPM_PS_D0 2'h0
`define PPM_PS_D3HOT 2'h3
`define PPM_CTX_BIT 3
`define PPM_WEE_BIT 8
`define PPM_WES_BIT 15
`define PPM_CTX_RST 1'h1

`define PPM_CAPABILITY_IDENTIFIER_LO 7
`define PPM_CAPABILITY_IDENTIFIER_HI 0
`define PPM_NXT_LO 15
`define PPM_NXT_HI 8
`define PPM_EN_BIT 16
`define PPM_MME_LO 22
`define PPM_MME_HI 20
`define PPM_A64_BIT 23
`define PPM_MSI_CAPABILITY_IDENTIFIER 8'h05
`define PPM_NXT_RST 8'h00
`define PPM_MDATA_LO 15

`define PPM_UPSTREAM_BIT 0

`endif

// file: rtl/ppm_msi_gen.v
`timescale 1ns/100ps
// Builds one MSI memory write and sends it on the upstream path
module ppm_msi_gen (
	input wire clk,
	input wire rst_n,
	input wire req,
	input wire enable,
	input wire [31:0] addr_lo,
	input wire [31:0] addr_hi,
	input wire [15:0] mdata,
	output reg wr_valid,
	output reg wr_wide,
	output reg [63:0] wr_addr,
	output reg [15:0] wr_data,
	output reg busy
);
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_valid <= 1'b0;
			wr_wide <= 1'b0;
			wr_addr <= 64'h0;
			wr_data <= 16'h0;
			busy <= 1'b0;
		end else begin
			wr_valid <= 1'b0;
			busy <= 1'b0;
			if (req && enable) begin
				wr_valid <= 1'b1;
				busy <= 1'b1;
				wr_wide <= (addr_hi != 32'h0);
				wr_addr <= (addr_hi != 32'h0) ? {addr_hi, addr_lo} : {32'h0, addr_lo};
				wr_data <= mdata;
			end
		end
	end
endmodule // ppm_msi_gen

// file: rtl/ppm_regs.v
// Operation
// - Two-bit power state reports current state; writes request a new one.
// - Context-kept bit three reads one by default.
// - Sticky wake enable bit eight, resets zero, allows wake messages.
// - Hot reset leaves wake enable unchanged; only full reset clears it.
// - Sticky wake status bit fifteen set on own wake event; write one clears.
// - Forwarded wake messages never set the wake status bit.
// - Upstream port wake status always reads zero.
// - Data select, scale and data fields read only zero.
// - MSI capability identifier low byte reads five.
// - MSI next pointer defaults zero; loader may overwrite.
// - MSI enable bit sixteen, read-write, reset zero, permits MSI.
// - Multi-message capable reads zero; multi-message enable has no effect.
// - Bit twenty-three reads one: 64-bit address capable.
// - MSI lower address bits 31:2 read-write reset zero; bits 1:0 zero.
// - All downstream MSIs go to root via upstream port.
// - Nonzero upper address gives 64-bit MSI write, else 32-bit.
// - MSI payload carries the programmed 16-bit message data.
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/100ps
`include "ppm_defines.vh"
module ppm_regs (
	input wire CLOCK,
	input wire RESET_N,
	input wire HOT_RESET_N,
	input wire LOADER_WE,
	input wire [7:0] LOADER_ADDR,
	input wire [31:0] LOADER_DATA,
	input wire PORT_WAKE_EVENT,
	input wire FWD_WAKE_MSG,
	input wire MSI_REQUEST,
	input wire WB_CYC_I,
	input wire WB_STB_I,
	input wire WB_WE_I,
	input wire [7:0] WB_ADR_I,
	input wire [3:0] WB_SEL_I,
	input wire [31:0] WB_DAT_I,
	output reg [31:0] WB_DAT_O,
	output reg WB_ACK_O,
	output reg [1:0] POWER_STATE,
	output reg WAKE_MSG_SEND,
	output reg FWD_WAKE_SEND,
	output reg MSI_WR_VALID,
	output reg MSI_WR_WIDE,
	output reg [63:0] MSI_WR_ADDR,
	output reg [15:0] MSI_WR_DATA
);
	reg hot_s1_q, hot_s2_q;
	reg wake_s1_q, wake_s2_q, wake_s3_q;
	reg fwd_s1_q, fwd_s2_q, fwd_s3_q;
	reg msi_s1_q, msi_s2_q, msi_s3_q;
	reg [1:0] power_state_field_q;
	reg ctx_q;
	reg wee_q;
	reg wes_q;
	reg [7:0] nxt_q;
	reg msi_en_q;
	reg [2:0] mme_q;
	reg [29:0] addr_lo_q;
	reg [31:0] addr_hi_q;
	reg [15:0] mdata_q;
	reg upstream_q;
	reg [31:0] rd_d;
	reg [31:0] wmask;
	wire wake_pulse;
	wire fwd_pulse;
	wire msi_pulse;
	wire wb_req;
	wire wb_wr;
	wire gen_valid, gen_wide, gen_busy;
	wire [63:0] gen_addr;
	wire [15:0] gen_data;
	wire [31:0] pmcs_wdata;
	wire pmcs_wr;

	assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	assign wb_wr = wb_req && WB_WE_I;
	assign wake_pulse = wake_s2_q && !wake_s3_q;
	assign fwd_pulse = fwd_s2_q && !fwd_s3_q;
	assign msi_pulse = msi_s2_q && !msi_s3_q;
	assign pmcs_wr = wb_wr && (WB_ADR_I == `PPM_OFS_PMCS);
	assign pmcs_wdata = WB_DAT_I & wmask;

	integer i;
	always @* begin
		for (i = 0; i < 4; i = i + 1) begin
			wmask[i*8 +: 8] = {8{WB_SEL_I[i]}};
		end
	end

	// Pin synchronisers
	always @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			hot_s1_q <= 1'b1;
			hot_s2_q <= 1'b1;
			wake_s1_q <= 1'b0;
			wake_s2_q <= 1'b0;
			wake_s3_q <= 1'b0;
			fwd_s1_q <= 1'b0;
			fwd_s2_q <= 1'b0;
			fwd_s3_q <= 1'b0;
			msi_s1_q <= 1'b0;
			msi_s2_q <= 1'b0;
			msi_s3_q <= 1'b0;
		end else begin
			hot_s1_q <= HOT_RESET_N;
			hot_s2_q <= hot_s1_q;
			wake_s1_q <= PORT_WAKE_EVENT;
			wake_s2_q <= wake_s1_q;
			wake_s3_q <= wake_s2_q;
			fwd_s1_q <= FWD_WAKE_MSG;
			fwd_s2_q <= fwd_s1_q;
			fwd_s3_q <= fwd_s2_q;
			msi_s1_q <= MSI_REQUEST;
			msi_s2_q <= msi_s1_q;
			msi_s3_q <= msi_s2_q;
		end
	end

	// Sticky bits: only the full reset clears them
	always @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			wee_q <= 1'b0;
			wes_q <= 1'b0;
		end else begin
			if (LOADER_WE && LOADER_ADDR == `PPM_OFS_PMCS) begin
				wee_q <= LOADER_DATA[`PPM_WEE_BIT];
			end else if (pmcs_wr && WB_SEL_I[1]) begin
				wee_q <= WB_DAT_I[`PPM_WEE_BIT];
			end
			if (upstream_q) begin
				wes_q <= 1'b0;
			end else if (wake_pulse) begin
				wes_q <= 1'b1;
			end else if (pmcs_wr && pmcs_wdata[`PPM_WES_BIT]) begin
				wes_q <= 1'b0;
			end
		end
	end

	// Non-sticky state: full reset clears all of it but sets ctx_q to one; hot reset clears all but ctx_q, nxt_q and upstream_q
	always @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			power_state_field_q <= `PPM_PS_D0;
			ctx_q <= `PPM_CTX_RST;
			nxt_q <= `PPM_NXT_RST;
			msi_en_q <= 1'b0;
			mme_q <= 3'h0;
			addr_lo_q <= 30'h0;
			addr_hi_q <= 32'h0;
			mdata_q <= 16'h0;
			upstream_q <= 1'b0;
		end else if (!hot_s2_q) begin
			power_state_field_q <= `PPM_PS_D0;
			msi_en_q <= 1'b0;
			mme_q <= 3'h0;
			addr_lo_q <= 30'h0;
			addr_hi_q <= 32'h0;
			mdata_q <= 16'h0;
		end else begin
			if (LOADER_WE) begin
				if (LOADER_ADDR == `PPM_OFS_PMCS) begin
					ctx_q <= LOADER_DATA[`PPM_CTX_BIT];
				end
				if (LOADER_ADDR == `PPM_OFS_MSI_CAPABILITY_CONTROL) begin
					nxt_q <= LOADER_DATA[`PPM_NXT_LO:`PPM_NXT_HI];
				end
				if (LOADER_ADDR == `PPM_OFS_PORTCFG) begin
					upstream_q <= LOADER_DATA[`PPM_UPSTREAM_BIT];
				end
			end
			if (pmcs_wr && WB_SEL_I[0]) begin
				if (WB_DAT_I[`PPM_PS_LO:`PPM_PS_HI] == `PPM_PS_D0 ||
					WB_DAT_I[`PPM_PS_LO:`PPM_PS_HI] == `PPM_PS_D3HOT) begin
					power_state_field_q <= WB_DAT_I[`PPM_PS_LO:`PPM_PS_HI];
				end
			end
			if (wb_wr && WB_ADR_I == `PPM_OFS_MSI_CAPABILITY_CONTROL && WB_SEL_I[2]) begin
				msi_en_q <= WB_DAT_I[`PPM_EN_BIT];
				mme_q <= WB_DAT_I[`PPM_MME_LO:`PPM_MME_HI];
			end
			if (wb_wr && WB_ADR_I == `PPM_OFS_MSILO) begin
				addr_lo_q <= (addr_lo_q & ~wmask[31:2]) | pmcs_wdata[31:2];
			end
			if (wb_wr && WB_ADR_I == `PPM_OFS_MSIUP) begin
				addr_hi_q <= (addr_hi_q & ~wmask) | pmcs_wdata;
			end
			if (wb_wr && WB_ADR_I == `PPM_OFS_MSIDATA) begin
				mdata_q <= (mdata_q & ~wmask[15:0]) | pmcs_wdata[15:0];
			end
		end
	end

	// Read mux; unmapped offsets read zero
	always @* begin
		rd_d = 32'h0;
		case (WB_ADR_I)
		`PPM_OFS_PMCS: begin
			rd_d[`PPM_PS_LO:`PPM_PS_HI] = power_state_field_q;
			rd_d[`PPM_CTX_BIT] = ctx_q;
			rd_d[`PPM_WEE_BIT] = wee_q;
			rd_d[`PPM_WES_BIT] = wes_q && !upstream_q;
		end
		`PPM_OFS_MSI_CAPABILITY_CONTROL: begin
			rd_d[`PPM_CAPABILITY_IDENTIFIER_LO:`PPM_CAPABILITY_IDENTIFIER_HI] = `PPM_MSI_CAPABILITY_IDENTIFIER;
			rd_d[`PPM_NXT_LO:`PPM_NXT_HI] = nxt_q;
			rd_d[`PPM_EN_BIT] = msi_en_q;
			rd_d[`PPM_MME_LO:`PPM_MME_HI] = mme_q;
			rd_d[`PPM_A64_BIT] = 1'b1;
		end
		`PPM_OFS_MSILO: rd_d = {addr_lo_q, 2'b00};
		`PPM_OFS_MSIUP: rd_d = addr_hi_q;
		`PPM_OFS_MSIDATA: rd_d = {16'h0, mdata_q};
		`PPM_OFS_PORTCFG: rd_d[`PPM_UPSTREAM_BIT] = upstream_q;
		default: rd_d = 32'h0;
		endcase
	end

	// Bus answer and event outputs
	always @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0;
			POWER_STATE <= `PPM_PS_D0;
			WAKE_MSG_SEND <= 1'b0;
			FWD_WAKE_SEND <= 1'b0;
			MSI_WR_VALID <= 1'b0;
			MSI_WR_WIDE <= 1'b0;
			MSI_WR_ADDR <= 64'h0;
			MSI_WR_DATA <= 16'h0;
		end else begin
			WB_ACK_O <= wb_req;
			WB_DAT_O <= (wb_req && !WB_WE_I) ? rd_d : 32'h0;
			POWER_STATE <= power_state_field_q;
			WAKE_MSG_SEND <= wake_pulse && wee_q && !upstream_q;
			FWD_WAKE_SEND <= fwd_pulse;
			MSI_WR_VALID <= gen_valid;
			MSI_WR_WIDE <= gen_wide;
			MSI_WR_ADDR <= gen_addr;
			MSI_WR_DATA <= gen_data;
		end
	end

	// Multi-message enable is ignored: always one message
	ppm_msi_gen u_gen (
		.clk(CLOCK),
		.rst_n(RESET_N),
		.req(msi_pulse && !upstream_q),
		.enable(msi_en_q),
		.addr_lo({addr_lo_q, 2'b00}),
		.addr_hi(addr_hi_q),
		.mdata(mdata_q),
		.wr_valid(gen_valid),
		.wr_wide(gen_wide),
		.wr_addr(gen_addr),
		.wr_data(gen_data),
		.busy()
	);
endmodule // ppm_regs

// file: dv/ppm_regs_props.sv
`timescale 1ns/100ps
module ppm_regs_props (
	input wire CLOCK,
	input wire RESET_N,
	input wire PORT_WAKE_EVENT,
	input wire MSI_REQUEST,
	input wire WB_CYC_I,
	input wire WB_STB_I,
	input wire WB_WE_I,
	input wire [7:0] WB_ADR_I,
	input wire [3:0] WB_SEL_I,
	input wire [31:0] WB_DAT_I,
	input wire [31:0] WB_DAT_O,
	input wire WB_ACK_O,
	input wire [1:0] POWER_STATE,
	input wire WAKE_MSG_SEND,
	input wire MSI_WR_VALID,
	input wire MSI_WR_WIDE,
	input wire [63:0] MSI_WR_ADDR
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);
	wire req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	wire rd = WB_ACK_O && !WB_WE_I;
	wire pmr = rd && WB_ADR_I == 8'hC4;
	wire psw = req && WB_WE_I && WB_ADR_I == 8'hC4 && WB_SEL_I[0];
	wire [1:0] psn = WB_DAT_I[1:0];
	AST_ACK: assert property (req |=> WB_ACK_O ##1 !WB_ACK_O) else $error("ack");
	AST_PS: assert property (psw && !(^psn) |-> ##2 POWER_STATE == $past(psn, 2)) else $error("ps");
	AST_PSR: assert property (psw && ^psn |-> ##2 POWER_STATE == $past(POWER_STATE, 2)) else $error("rsv ps");
	AST_CTX: assert property (pmr |-> WB_DAT_O[3] && WB_DAT_O[1:0] == POWER_STATE) else $error("ctx");
	AST_RSV: assert property (pmr |-> {WB_DAT_O[31:16], WB_DAT_O[14:9], WB_DAT_O[7:4], WB_DAT_O[2]} == 0) else $error("rsv");
	AST_CAP: assert property (rd && WB_ADR_I == 8'hD0 |-> WB_DAT_O[7:0] == 8'h05 && WB_DAT_O[23] && WB_DAT_O[19:17] == 0) else $error("cap");
	AST_LO: assert property (rd && WB_ADR_I == 8'hD4 |-> WB_DAT_O[1:0] == 0) else $error("lo");
	AST_WIDE: assert property (MSI_WR_VALID |-> MSI_WR_WIDE == |MSI_WR_ADDR[63:32]) else $error("wide");
	AST_MSI: assert property (MSI_WR_VALID |-> $past(MSI_REQUEST, 3)) else $error("msi");
	AST_WAKE: assert property (WAKE_MSG_SEND |-> $past(PORT_WAKE_EVENT, 3)) else $error("wake");
endmodule // ppm_regs_props
bind ppm_regs ppm_regs_props ppm_regs_props_inst (.*);

// file: dv/ppm_rc_model.sv
`timescale 1ns/100ps
module ppm_rc_model (
	input wire clk,
	input wire ack,
	input wire [31:0] din,
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [7:0] adr,
	output logic [3:0] sel,
	output logic [31:0] dout
);
	initial {cyc, stb, we, adr, sel, dout} = '0;
	// Request held until ack is seen at a rising edge
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		{cyc, stb, we, adr, sel, dout} <= {2'b11, w, a, 4'hF, d};
		do @(posedge clk); while (ack !== 1'b1);
		q = din;
		// Released address and data lines show the inverse, not stale values; cyc, stb, we and sel go low
		{cyc, stb, we, adr, sel, dout} <= {3'b000, ~a, 4'h0, ~d};
	endtask
endmodule // ppm_rc_model

// file: dv/ppm_regs_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; $display("ERROR %0t got %h exp %h", $time, a, b); end end
module ppm_regs_tb;
	logic clk = 0, rst_n = 0, hot_n = 1, ld = 0, wake = 0, fwd = 0, msi = 0;
	logic cyc, stb, we, ack, wide, val, ws, fs;
	logic [7:0] la = 0, adr;
	logic [3:0] sel;
	logic [1:0] ps, eps;
	logic [2:0] outs;
	logic [15:0] md, mdat;
	logic [31:0] ldat = 0, q, v, lo, hi, wd, rdat;
	logic [63:0] ma;
	int miscompares = 0, tests_run = 0, seen;
	ppm_regs ppm_regs_inst (.CLOCK(clk), .RESET_N(rst_n), .HOT_RESET_N(hot_n), .LOADER_WE(ld),
		.LOADER_ADDR(la), .LOADER_DATA(ldat), .PORT_WAKE_EVENT(wake), .FWD_WAKE_MSG(fwd),
		.MSI_REQUEST(msi), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(rdat), .WB_ACK_O(ack), .POWER_STATE(ps),
		.WAKE_MSG_SEND(ws), .FWD_WAKE_SEND(fs), .MSI_WR_VALID(val), .MSI_WR_WIDE(wide),
		.MSI_WR_ADDR(ma), .MSI_WR_DATA(mdat));
	ppm_rc_model ppm_rc_model_inst (.clk(clk), .ack(ack), .din(rdat), .cyc(cyc), .stb(stb),
		.we(we), .adr(adr), .sel(sel), .dout(wd));
	initial forever #20 clk = ~clk;
	function logic [1:0] next_ps(logic [1:0] o, logic [1:0] n);
		return (n[1] ^ n[0]) ? o : n;
	endfunction
	task wr(logic [7:0] a, logic [31:0] d);
		ppm_rc_model_inst.xfer(1'b1, a, d, q);
	endtask
	task rd(logic [7:0] a, logic [31:0] e);
		ppm_rc_model_inst.xfer(1'b0, a, 32'h0, q);
		`CHK(q, e)
	endtask
	task load(logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		{ld, la, ldat} <= {1'b1, a, d};
		@(posedge clk);
		ld <= 1'b0;
	endtask
	// Pin k high for ten cycles, counting the matching output pulses
	task kick(int k);
		seen = 0;
		@(posedge clk);
		{msi, fwd, wake} <= 3'b1 << k;
		repeat (10) begin
			@(posedge clk);
			outs = {val, fs, ws};
			if (outs[k] === 1'b1) seen++;
		end
		{msi, fwd, wake} <= 3'h0;
		repeat (3) @(posedge clk);
	endtask
	task print_verdict;
		if (miscompares == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		#300us;
		miscompares++;
		print_verdict;
	end
	initial begin
		v = $urandom(26260);
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'hC4, 32'h8);
		rd(8'hD0, 32'h80_0005);
		rd(8'hD4, 32'h0);
		rd(8'h40, 32'h0);
		eps = 2'h0;
		for (int i = 0; i < 8; i++) begin
			v = (i < 2) ? 3 - 2 * i : $urandom;
			wr(8'hC4, v & 32'h3);
			eps = next_ps(eps, v[1:0]);
			rd(8'hC4, 32'h8 | eps);
			`CHK(ps, eps)
		end
		wr(8'hC4, 32'h0);
		v = $urandom;
		wr(8'hD0, v);
		rd(8'hD0, 32'h80_0005 | v & 32'h71_0000);
		wr(8'hD0, 32'h1_0000);
		for (int i = 0; i < 2; i++) begin
			lo = $urandom;
			hi = i ? $urandom | 1 : 0;
			md = $urandom;
			wr(8'hD4, lo);
			wr(8'hD8, hi);
			wr(8'hDC, {16'h0, md});
			kick(2);
			`CHK(seen, 1)
			`CHK(wide, i[0])
			`CHK(ma, {hi, lo & ~32'h3})
			`CHK(mdat, md)
		end
		wr(8'hD0, 32'h0);
		kick(2);
		`CHK(seen, 0)
		load(8'hC4, 32'h108);
		kick(0);
		`CHK(seen, 1)
		rd(8'hC4, 32'h8108);
		@(posedge clk);
		hot_n <= 1'b0;
		repeat (6) @(posedge clk);
		hot_n <= 1'b1;
		repeat (4) @(posedge clk);
		rd(8'hC4, 32'h8108);
		wr(8'hC4, 32'h8100);
		kick(1);
		`CHK(seen, 1)
		rd(8'hC4, 32'h108);
		wr(8'hC4, 32'h0);
		kick(0);
		`CHK(seen, 0)
		rd(8'hC4, 32'h8008);
		load(8'hE0, 32'h1);
		wr(8'hC4, 32'h8000);
		kick(0);
		rd(8'hC4, 32'h8);
		print_verdict;
	end
endmodule // ppm_regs_tb
